/* File: hdl/asf_framer.sv */
// audio serializer input framer: capture, frame build, scramble, serialize
// Behaviour
// [RULE1] all inputs captured only by reference clock; code samples all pins on CLK_I, reference edges only time frames
// [RULE2] eight data, four gpi, control channel carried
// [RULE3] reference clock 10 to 50 MHz
// [RULE4] idle reference switches framing to oscillator
// [RULE5] two-bit select sets oscillator frequency
// [RULE6] twenty-eight serial bits per frame cycle
// [RULE7] frame holds audio, sync, control, parity
// [RULE8] payload scrambled and dc balanced
// [RULE9] full duplex control path shares link
// [RULE10] source generates bit and word clocks
// [RULE11] bit clock fast enough for samples
// [RULE12] word select low left, high right
// [RULE13] i2s word select leads msb one bit
// [RULE14] samples two's complement, msb first
// [RULE15] truncate long words, zero fill short
// [RULE16] latch data on rising bit clock
// [RULE17] left-justified msb aligns with word select
// [RULE18] right-justified lsb precedes word select edge
// [RULE19] tdm channels per line power of two
// [RULE20] configurable alignment i2s or left-justified
// [RULE21] idle detect counts oscillator cycles
//
// Local design decision: the APB interface to the registers.
module asf_framer (
  input  wire logic        CLK_I,          // 25 MHz system / oscillator clock
  input  wire logic        SYS_RST_I,      // synchronous reset, active high
  input  wire logic        REF_CLK_I,      // audio system reference clock pin
  input  wire logic        SER_BIT_CLK_I,  // serial_bit_clock pin
  input  wire logic        WORD_SEL_CLK_I, // word_select_clock pin
  input  wire logic [7:0]  AUDIO_DATA_I,   // audio data lines
  input  wire logic [3:0]  GEN_IN_PINS_I,  // general_input_pins
  input  wire logic        CC_RX_I,        // control channel back bit in
  input  wire logic        PSEL_I,         // apb select
  input  wire logic        PENABLE_I,      // apb enable
  input  wire logic        PWRITE_I,       // apb direction
  input  wire logic [7:0]  PADDR_I,        // apb byte address
  input  wire logic [31:0] PWDATA_I,       // apb write data
  output logic      [31:0] PRDATA_O,       // apb read data
  output logic             PREADY_O,       // apb ready
  output logic             PSLVERR_O,      // apb error
  output logic             SER_OUT_O,      // forward serial bit
  output logic             FRAME_START_O,  // pulse on first frame bit
  output logic             ON_OSC_O        // framing runs on oscillator
);
  // ==========================================================================
  // input synchronisers (two flops, first read only by second)
  logic [13:0] sync1_reg;   // first stage
  logic [13:0] sync2_reg;   // second stage
  logic [13:0] pin_bus;     // gathered pins
  assign pin_bus = {CC_RX_I, GEN_IN_PINS_I, AUDIO_DATA_I, WORD_SEL_CLK_I};

  // synchronise audio pins and control bit
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      sync1_reg <= 14'h0000;
      sync2_reg <= 14'h0000;
    end
    else
    begin
      sync1_reg <= pin_bus;
      sync2_reg <= sync1_reg;
    end
  end

  // clocks sampled separately
  logic [2:0] bck_reg;   // bit clock sync + history
  logic [2:0] ref_reg;   // reference clock sync + history

  // bit clock and reference clock sampling
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      bck_reg <= 3'h0;
      ref_reg <= 3'h0;
    end
    else
    begin
      bck_reg <= {bck_reg[1:0], SER_BIT_CLK_I};
      ref_reg <= {ref_reg[1:0], REF_CLK_I};  // see [RULE3]
    end
  end

  logic       ws_s;        // synced word select
  logic [7:0] data_s;      // synced data lines
  logic [3:0] gpi_s;       // synced general inputs
  logic       cc_rx_s;     // synced control bit
  logic       bck_rise;    // bit clock rising edge
  logic       ref_rise;    // reference clock rising edge
  assign ws_s     = sync2_reg[0];
  assign data_s   = sync2_reg[8:1];
  assign gpi_s    = sync2_reg[12:9];
  assign cc_rx_s  = sync2_reg[13];
  assign bck_rise = bck_reg[1] & ~bck_reg[2];  // see [RULE16]
  assign ref_rise = ref_reg[1] & ~ref_reg[2];  // see [RULE1]

  // ==========================================================================
  // registers
  logic [7:0]  clk_sel_reg;     // internal_clock_select
  logic        align_reg;       // alignment select
  logic [7:0]  idle_limit_reg;  // idle threshold
  logic [7:0]  cc_tx_reg;       // outbound control byte
  logic [7:0]  cc_rx_reg;       // inbound control byte
  logic [3:0]  hist_rd_reg;     // history read pointer

  // ==========================================================================
  // reference idle detection and clock selection
  logic [7:0] idle_cnt_reg;   // oscillator cycles since a reference edge
  logic       on_osc_reg;     // fallback active

  // count cycles without reference edge
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      idle_cnt_reg <= 8'h00;
      on_osc_reg   <= 1'b1;
    end
    else if (ref_rise)
    begin
      idle_cnt_reg <= 8'h00;
      on_osc_reg   <= 1'b0;                           // see [RULE21]
    end
    else if (idle_cnt_reg >= idle_limit_reg)
    begin
      on_osc_reg <= 1'b1;                             // see [RULE4] [RULE21]
    end
    else
    begin
      idle_cnt_reg <= idle_cnt_reg + 8'h01;
    end
  end

  // oscillator divider reload from select field
  logic [1:0] osc_sel;
  logic [1:0] osc_div;
  assign osc_sel = clk_sel_reg[asf_pkg::OSC_SEL_MSB:asf_pkg::OSC_SEL_LSB];
  always_comb
  begin
    case (osc_sel)                                    // see [RULE5]
      2'h1:    osc_div = asf_pkg::OSC_DIV_50;
      2'h3:    osc_div = asf_pkg::OSC_DIV_12;
      default: osc_div = asf_pkg::OSC_DIV_25;
    endcase
  end

  // oscillator tick generator
  logic [1:0] osc_cnt_reg;   // divider count
  logic       osc_tick;      // one frame tick from oscillator
  assign osc_tick = (osc_cnt_reg == 2'h0);
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      osc_cnt_reg <= 2'h0;
    end
    else if (osc_tick)
    begin
      osc_cnt_reg <= osc_div;
    end
    else
    begin
      osc_cnt_reg <= osc_cnt_reg - 2'h1;
    end
  end

  // frame tick: reference edge or oscillator tick
  logic frame_tick;
  assign frame_tick = on_osc_reg ? osc_tick : ref_rise;  // see [RULE4]

  // ==========================================================================
  // audio word capture, per line shift registers
  logic       ws_prev_reg;     // word select at last bit edge
  logic [5:0] bit_idx_reg;     // bit position in current word
  logic       ws_edge;         // word select changed
  assign ws_edge = (ws_s != ws_prev_reg);

  // track word select and bit position
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ws_prev_reg <= 1'b0;
      bit_idx_reg <= 6'h3F;
    end
    else if (bck_rise)
    begin
      ws_prev_reg <= ws_s;
      if (ws_edge)
      begin
        // i2s: msb arrives next bit, lj: msb is this bit
        bit_idx_reg <= (align_reg == asf_pkg::ALIGN_I2S) ? 6'h00 : 6'h01; // see [RULE13] [RULE17]
      end
      else if (bit_idx_reg != 6'h3F)
      begin
        bit_idx_reg <= bit_idx_reg + 6'h01;
      end
    end
  end

  logic [31:0] shift_reg [0:7];   // words being assembled
  logic [31:0] word_reg  [0:7];   // last completed words
  logic        cap_bit;           // current edge holds a word bit
  logic [5:0]  cap_pos;           // index into word, msb is 0
  assign cap_bit = ws_edge ? (align_reg == asf_pkg::ALIGN_LJ)
                           : (bit_idx_reg < 6'h20);
  assign cap_pos = ws_edge ? 6'h00 : bit_idx_reg;

  genvar g;
  generate
    for (g = 0; g < asf_pkg::N_DATA; g = g + 1)
    begin : g_line
      // shift one line: msb first, extra bits dropped, missing bits zero
      always_ff @(posedge CLK_I)
      begin
        if (SYS_RST_I)
        begin
          shift_reg[g] <= 32'h00000000;
          word_reg[g]  <= 32'h00000000;
        end
        else if (bck_rise)
        begin
          if (ws_edge)
          begin
            word_reg[g]  <= shift_reg[g];                 // see [RULE14]
            if (align_reg == asf_pkg::ALIGN_I2S && bit_idx_reg < 6'h20)
            begin
              // i2s: the bit beside the word select edge is the old word's lsb
              word_reg[g][5'd31 - bit_idx_reg[4:0]] <= data_s[g];  // see [RULE13]
            end
            shift_reg[g] <= cap_bit ? {data_s[g], 31'h0} : 32'h00000000; // see [RULE15]
          end
          else if (cap_bit)
          begin
            shift_reg[g][5'd31 - cap_pos[4:0]] <= data_s[g]; // see [RULE14] [RULE15]
          end
        end
      end
    end
  endgenerate

  // history memory of completed line 0 words, written the cycle after a word closes
  logic [31:0] hist_rdata;   // registered memory read data
  logic [3:0]  hist_wr_reg;  // next history slot
  logic        hist_we_reg;  // completed word waiting in word_reg[0]
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      hist_wr_reg <= 4'h0;
      hist_we_reg <= 1'b0;
    end
    else
    begin
      hist_we_reg <= bck_rise & ws_edge;
      if (hist_we_reg)
      begin
        hist_wr_reg <= hist_wr_reg + 4'h1;
      end
    end
  end

  // read address taken from the bus in setup so data is ready at the access edge
  asf_word_mem u_mem (
    .clk_i   (CLK_I),
    .we_i    (hist_we_reg),
    .waddr_i (hist_wr_reg),
    .wdata_i (word_reg[0]),
    .raddr_i ((PSEL_I & ~PENABLE_I) ? PADDR_I[5:2] : hist_rd_reg),
    .rdata_o (hist_rdata)
  );

  // ==========================================================================
  // frame assembly: 8 audio, ws, bck, 4 gpi, cc, parity, pad
  logic [26:0] payload;    // unscrambled payload without parity
  logic [2:0]  cc_idx_reg; // control bit pointer
  assign payload = {12'h000, cc_tx_reg[cc_idx_reg], gpi_s, bck_reg[1], ws_s,
                    data_s};  // see [RULE2] [RULE7] [RULE12]

  // lfsr scrambler state
  logic [14:0] lfsr_reg;
  logic [26:0] scr_mask;
  assign scr_mask = {lfsr_reg[11:0], lfsr_reg};

  logic [27:0] shreg;          // serial shift register
  logic [4:0]  bit_cnt_reg;    // bits left in frame
  logic        dc_flip_reg;    // alternate inversion for balance
  logic [26:0] scr;
  assign scr = (payload ^ scr_mask) ^ {27{dc_flip_reg}};  // see [RULE8]

  // serializer: one bit per clock; line rate scales with frame tick in silicon
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      shreg         <= 28'h0000000;
      bit_cnt_reg   <= 5'h00;
      lfsr_reg      <= 15'h7FFF;
      dc_flip_reg   <= 1'b0;
      cc_idx_reg    <= 3'h0;
      SER_OUT_O     <= 1'b0;
      FRAME_START_O <= 1'b0;
    end
    else
    begin
      FRAME_START_O <= 1'b0;
      if (frame_tick && bit_cnt_reg == 5'h00)
      begin
        // load frame: scrambled payload plus parity bit
        shreg         <= {^scr, scr};                       // see [RULE6] [RULE7]
        bit_cnt_reg   <= 5'd27;
        lfsr_reg      <= {lfsr_reg[13:0], lfsr_reg[14] ^ lfsr_reg[13]};
        dc_flip_reg   <= ~dc_flip_reg;                      // see [RULE8]
        cc_idx_reg    <= cc_idx_reg + 3'h1;                 // see [RULE9]
        SER_OUT_O     <= ^scr;
        FRAME_START_O <= 1'b1;
      end
      else if (bit_cnt_reg != 5'h00)
      begin
        SER_OUT_O   <= shreg[bit_cnt_reg - 5'h01];
        bit_cnt_reg <= bit_cnt_reg - 5'h01;
      end
    end
  end

  // inbound control channel: one bit per frame, full duplex
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      cc_rx_reg <= 8'h00;
    end
    else if (FRAME_START_O)
    begin
      cc_rx_reg <= {cc_rx_reg[6:0], cc_rx_s};  // see [RULE9]
    end
  end

  // ==========================================================================
  // apb slave: one wait state, error on unmapped
  logic acc;
  logic mapped;
  assign acc    = PSEL_I & PENABLE_I;
  always_comb
  begin
    case (PADDR_I)
      asf_pkg::OFS_CLK_SEL, asf_pkg::OFS_FMT_CTRL, asf_pkg::OFS_STATUS,
      asf_pkg::OFS_IDLE_LIMIT, asf_pkg::OFS_CC_TX, asf_pkg::OFS_CC_RX: mapped = 1'b1;
      default: mapped = (PADDR_I[7:6] == 2'h1);   // history window 0x40..0x7C
    endcase
  end

  // register writes
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      clk_sel_reg    <= asf_pkg::CLK_SEL_RST;
      align_reg      <= asf_pkg::ALIGN_I2S;
      idle_limit_reg <= asf_pkg::IDLE_LIMIT_RST;
      cc_tx_reg      <= 8'h00;
    end
    else if (PSEL_I && !PENABLE_I && PWRITE_I)
    begin
      // setup phase: nothing stored yet
    end
    else if (acc && PWRITE_I && PREADY_O)
    begin
      case (PADDR_I)
        asf_pkg::OFS_CLK_SEL:    clk_sel_reg    <= {5'h00, PWDATA_I[2:0]};
        asf_pkg::OFS_FMT_CTRL:   align_reg      <= PWDATA_I[0];  // see [RULE20]
        asf_pkg::OFS_IDLE_LIMIT: idle_limit_reg <= PWDATA_I[7:0];
        asf_pkg::OFS_CC_TX:      cc_tx_reg      <= PWDATA_I[7:0];
        default:                 cc_tx_reg      <= cc_tx_reg;
      endcase
    end
  end

  // handshake: ready rises one cycle into access, reads allow memory latency
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      PREADY_O    <= 1'b0;
      PSLVERR_O   <= 1'b0;
      PRDATA_O    <= 32'h00000000;
      hist_rd_reg <= 4'h0;
    end
    else if (PSEL_I && !PENABLE_I)
    begin
      hist_rd_reg <= PADDR_I[5:2];
      PREADY_O    <= 1'b0;
      PSLVERR_O   <= 1'b0;
    end
    else if (acc && !PREADY_O)
    begin
      PREADY_O  <= 1'b1;
      PSLVERR_O <= ~mapped;
      case (PADDR_I)
        asf_pkg::OFS_CLK_SEL:    PRDATA_O <= {24'h000000, clk_sel_reg};
        asf_pkg::OFS_FMT_CTRL:   PRDATA_O <= {31'h00000000, align_reg};
        asf_pkg::OFS_STATUS:     PRDATA_O <= {23'h000000, on_osc_reg, idle_cnt_reg};
        asf_pkg::OFS_IDLE_LIMIT: PRDATA_O <= {24'h000000, idle_limit_reg};
        asf_pkg::OFS_CC_TX:      PRDATA_O <= {24'h000000, cc_tx_reg};
        asf_pkg::OFS_CC_RX:      PRDATA_O <= {24'h000000, cc_rx_reg};
        default:                 PRDATA_O <= mapped ? hist_rdata : 32'h00000000;
      endcase
    end
    else
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

  // fallback indicator
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ON_OSC_O <= 1'b1;
    end
    else
    begin
      ON_OSC_O <= on_osc_reg;
    end
  end
endmodule : asf_framer

/* File: hdl/asf_word_mem.sv */
// small memory holding captured audio words, registered read data
module asf_word_mem (
  input  wire logic        clk_i,     // system clock
  input  wire logic        we_i,      // write strobe
  input  wire logic [3:0]  waddr_i,   // write address
  input  wire logic [31:0] wdata_i,   // write data
  input  wire logic [3:0]  raddr_i,   // read address
  output logic      [31:0] rdata_o    // registered read data
);
  // ==========================================================================
  // storage
  logic [31:0] mem_reg [0:asf_pkg::HIST_DEPTH-1];  // word array

  // write port
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // registered read port
  always_ff @(posedge clk_i)
  begin
    rdata_o <= mem_reg[raddr_i];
  end
endmodule : asf_word_mem

/* File: shared/asf_pkg.sv */
// package of constants shared by the audio serializer input framer
package asf_pkg;

  // ==========================================================================
  // register map (byte addresses on apb)
  localparam logic [7:0]  OFS_CLK_SEL      = 8'h14;  // internal_clock_select
  localparam logic [7:0]  OFS_FMT_CTRL     = 8'h20;  // alignment select
  localparam logic [7:0]  OFS_STATUS       = 8'h24;  // clock source status
  localparam logic [7:0]  OFS_IDLE_LIMIT   = 8'h28;  // idle detect threshold
  localparam logic [7:0]  OFS_CC_TX        = 8'h2C;  // control channel outbound byte
  localparam logic [7:0]  OFS_CC_RX        = 8'h30;  // control channel inbound byte

  // ==========================================================================
  // field positions and reset values
  localparam int          OSC_SEL_LSB      = 1;      // clock source field [2:1]
  localparam int          OSC_SEL_MSB      = 2;
  localparam logic [7:0]  CLK_SEL_RST      = 8'h00;  // reset of select register
  localparam logic [7:0]  IDLE_LIMIT_RST   = 8'h10;  // osc cycles w/o ref edge
  localparam int          FRAME_BITS       = 28;     // forward frame length
  localparam int          N_DATA           = 8;      // audio data lines
  localparam int          N_GPI            = 4;      // general inputs
  localparam int          WORD_BITS        = 32;     // capture word length
  localparam int          HIST_DEPTH       = 16;     // captured words kept

  // ==========================================================================
  // oscillator divider reload per select code (base osc 50 MHz equivalent)
  localparam logic [1:0]  OSC_DIV_25       = 2'h1;   // 00 and 10: ~25 MHz
  localparam logic [1:0]  OSC_DIV_50       = 2'h0;   // 01: ~50 MHz
  localparam logic [1:0]  OSC_DIV_12       = 2'h3;   // 11: ~12.5 MHz

  // alignment of the msb relative to word select
  typedef enum logic {ALIGN_I2S, ALIGN_LJ} asf_align_t;

endpackage : asf_pkg

/* File: verification/asf_framer_chk.sv */
// port checker of the audio serializer input framer
module asf_framer_chk (
  input  wire logic        CLK_I,          // system clock
  input  wire logic        SYS_RST_I,      // synchronous reset
  input  wire logic        REF_CLK_I,      // reference clock pin
  input  wire logic        PSEL_I,         // apb select
  input  wire logic        PENABLE_I,      // apb enable
  input  wire logic [31:0] PRDATA_O,       // apb read data
  input  wire logic        PREADY_O,       // apb ready
  input  wire logic        PSLVERR_O,      // apb error
  input  wire logic        SER_OUT_O,      // serial bit
  input  wire logic        FRAME_START_O,  // frame pulse
  input  wire logic        ON_OSC_O        // oscillator in use
);
  // ==========================================================================
  // helper counters
  logic       ref_reg;   // reference level one cycle ago
  logic [4:0] gap_reg;   // cycles since last frame start
  logic [7:0] idle_reg;  // cycles since reference moved
  logic [7:0] act_reg;   // cycles with a live reference
  // last reference level
  always_ff @(posedge CLK_I)
    ref_reg <= REF_CLK_I;
  // frame spacing, saturating
  always_ff @(posedge CLK_I)
    if (SYS_RST_I) gap_reg <= 5'h1F;
    else if (FRAME_START_O) gap_reg <= 5'h00;
    else if (gap_reg != 5'h1F) gap_reg <= gap_reg + 5'h01;
  // quiet time of the reference
  always_ff @(posedge CLK_I)
    if (SYS_RST_I || REF_CLK_I != ref_reg) idle_reg <= 8'h00;
    else if (idle_reg != 8'hFF) idle_reg <= idle_reg + 8'h01;
  // live time of the reference
  always_ff @(posedge CLK_I)
    if (SYS_RST_I || idle_reg >= 8'h08) act_reg <= 8'h00;
    else if (act_reg != 8'hFF) act_reg <= act_reg + 8'h01;
  // ==========================================================================
  // assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  rst_vals_a: assert property (disable iff (1'b0) SYS_RST_I |=>
    ON_OSC_O && !PREADY_O && !SER_OUT_O && !FRAME_START_O) else $error("reset values");
  ready_time_a: assert property (PSEL_I && $rose(PENABLE_I) |=> PREADY_O)
    else $error("ready late");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
  ready_idle_a: assert property (!PSEL_I |=> !PREADY_O) else $error("ready unasked");
  err_zero_a: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
    else $error("error reply");
  frame_gap_a: assert property (FRAME_START_O |-> gap_reg >= 5'd27)
    else $error("frames too close");
  osc_fallback_a: assert property (idle_reg == 8'hFF |-> ON_OSC_O)
    else $error("no fallback");
  osc_return_a: assert property (act_reg == 8'hFF |-> !ON_OSC_O)
    else $error("no return");
  osc_hold_a: assert property (!ON_OSC_O && idle_reg < 8'h08 |=> !ON_OSC_O)
    else $error("early fallback");
  cov_frame_c: cover property (FRAME_START_O);
  cov_err_c: cover property (PSLVERR_O);
  cov_ref_c: cover property ($fell(ON_OSC_O));
  cov_osc_c: cover property ($rose(ON_OSC_O));
endmodule : asf_framer_chk

bind asf_framer asf_framer_chk u_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .REF_CLK_I(REF_CLK_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SER_OUT_O(SER_OUT_O),
  .FRAME_START_O(FRAME_START_O), .ON_OSC_O(ON_OSC_O));

/* File: verification/asf_src_model.sv */
// behavioural audio source: reference, bit and word clocks, data lines
module asf_src_model (
  input  wire logic       ref_en_i,   // reference clock runs
  output logic            ref_clk_o,  // reference clock, 10 MHz
  output logic            bck_o,      // serial_bit_clock, 320 ns
  output logic            ws_o,       // word_select_clock
  output logic      [7:0] data_o      // audio data lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels: clocks still, word select high
  initial
  begin
    ref_clk_o = 1'b0;
    bck_o = 1'b0;
    ws_o = 1'b1;
    data_o = 8'h00;
  end
  // reference stands low when stopped (pull-down)
  always #50 ref_clk_o = ref_en_i ? ~ref_clk_o : 1'b0;
  // ==========================================================================
  // four slots of left/right words, then a zero slot to close the last word
  task automatic send(input logic lj, input int nbits, input logic [39:0] wl,
                      input logic [39:0] wr);
    logic        d;     // bit of the left-justified stream
    logic        prev;  // bit one period earlier
    logic [39:0] w;     // word of the current slot
    prev = 1'b0;
    for (int t = 0; t < 5 * nbits; t++)
    begin
      w = ((t / nbits) % 2 == 1) ? wr : wl;
      if (t / nbits == 4) w = 40'h0;
      d = w[39 - (t % nbits)];                       // msb first
      #160 bck_o = 1'b0;                             // data moves on falling edge
      ws_o = 1'((t / nbits) % 2);                    // low left, high right
      data_o = {{7{~(lj ? d : prev)}}, lj ? d : prev}; // i2s lags one bit
      prev = d;
      #160 bck_o = 1'b1;                             // one pulse per bit
    end
    #160 bck_o = 1'b0;
    data_o = ~data_o;                                // released lines flip
  endtask : send
endmodule : asf_src_model

/* File: verification/tb_top.sv */
// self-checking bench of the audio serializer input framer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, ref_en, ref_clk, serial_bit_clock, ws, psel, pen, pwr;  // drives
  logic [7:0]  data, paddr;                                      // lines, address
  logic [31:0] pwdata, prdata, rd;                               // apb data
  logic        pready, pslverr, er, ser, fstart, on_osc, cc_in;  // replies, cc bit
  int          n_fail, num_checks;                               // tallies
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  asf_src_model u_src (.ref_en_i(ref_en), .ref_clk_o(ref_clk), .bck_o(serial_bit_clock), .ws_o(ws),
    .data_o(data));
  asf_framer u_dut (.CLK_I(clk), .SYS_RST_I(rst), .REF_CLK_I(ref_clk), .SER_BIT_CLK_I(serial_bit_clock),
    .WORD_SEL_CLK_I(ws), .AUDIO_DATA_I(data), .GEN_IN_PINS_I(4'h5), .CC_RX_I(cc_in),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SER_OUT_O(ser),
    .FRAME_START_O(fstart), .ON_OSC_O(on_osc));
  // ==========================================================================
  // reporting
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // a wait ran out
  task automatic hang(input string what);
    chk(what, 32'h1, 32'h0);
    final_report();
  endtask : hang
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) hang("apb ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // wait for a level of the oscillator flag, giving the cycles spent
  task automatic wait_osc(input logic lvl, output int n);
    for (n = 0; on_osc !== lvl; n++)
    begin
      @(negedge clk);
      if (n > 400) hang("on_osc wait");
    end
  endtask : wait_osc
  // even parity across one 28-bit frame
  task automatic frame_par();
    logic p;
    for (int n = 0; fstart !== 1'b1; n++)
    begin
      @(negedge clk);
      if (n > 100) hang("frame wait");
    end
    p = ser;
    repeat (27) @(negedge clk) p = p ^ ser;
    chk("frame parity", 32'h0, {31'h0, p});
  endtask : frame_par
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    @(negedge clk);
    chk("reset outputs", 32'h1, {27'h0, pready, pslverr, ser, fstart, on_osc});
    chk("reset read data", 32'h0, prdata);
    apb(1'b0, 8'h14, 32'h0);
    chk("clock select reset", 32'h0, rd);
    apb(1'b0, 8'h28, 32'h0);
    chk("idle limit reset", 32'h10, rd);
    apb(1'b0, 8'h24, 32'h0);
    chk("status on_osc", 32'h1, {31'h0, rd[8]});
  endtask : t_reset
  // unmapped place and read-only inbound byte, outbound byte kept
  task automatic t_regs();
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    chk("unmapped write err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped read", 32'h1, {rd[30:0], er});
    apb(1'b1, 8'h2C, 32'hA5);
    apb(1'b0, 8'h2C, 32'h0);
    chk("cc out byte", 32'hA5, rd);
    apb(1'b1, 8'h30, 32'hFF);
    apb(1'b0, 8'h30, 32'h0);
    chk("cc in byte", 32'h0, rd);
    cc_in <= 1'b1;
    repeat (10) frame_par();
    apb(1'b0, 8'h30, 32'h0);
    chk("cc in stream", 32'hFF, rd);
  endtask : t_regs
  // every oscillator code while the reference is stopped
  task automatic t_osc_sel();
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, 8'h14, 32'(s << 1));
      apb(1'b0, 8'h14, 32'h0);
      chk("clock select", 32'(s << 1), rd);
      frame_par();
      chk("on oscillator", 32'h1, {31'h0, on_osc});
    end
  endtask : t_osc_sel
  // reference starts, then stops again
  task automatic t_ref();
    int n;
    apb(1'b1, 8'h14, 32'h2);
    ref_en <= 1'b1;
    wait_osc(1'b0, n);
    apb(1'b0, 8'h24, 32'h0);
    chk("status on ref", 32'h0, {31'h0, rd[8]});
    frame_par();
    ref_en <= 1'b0;
    wait_osc(1'b1, n);
    chk("idle wait", 32'h1, {31'h0, n >= 13});
  endtask : t_ref
  // two stereo frames captured, then found in the history
  task automatic t_audio(input logic lj, input int nb, input logic [39:0] wl,
                         input logic [39:0] wr);
    int hl, hr;
    hl = 0;
    hr = 0;
    ref_en <= 1'b1;
    apb(1'b1, 8'h20, {31'h0, lj});
    u_src.send(lj, nb, wl, wr);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b0, 8'(8'h40 + 4 * i), 32'h0);
      if (rd === wl[39:8]) hl++;
      if (rd === wr[39:8]) hr++;
    end
    chk("left word found", 32'h1, {31'h0, hl > 0});
    chk("right word found", 32'h1, {31'h0, hr > 0});
  endtask : t_audio
  // ==========================================================================
  // main sequence
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    rst = 1'b1;
    ref_en = 1'b0;
    cc_in = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_osc_sel();
    t_ref();
    t_audio(1'b0, 24, 40'h8123450000, 40'h7EDCBA0000);
    t_audio(1'b1, 40, 40'hA5C396E17B, 40'h5A3C691E84);
    final_report();
  end
endmodule : tb_top
